/* include/dpc_cfg.svh */
// constants of the dual pot serial command slave
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

// timing
`define DPC_CLK_MHZ          250
`define DPC_NV_WRITE_TIME_US 5000

// opcodes, upper nibble of the instruction byte
`define DPC_OP_RD_WIPER      4'h9
`define DPC_OP_WR_WIPER      4'ha
`define DPC_OP_RD_SLOT       4'hb
`define DPC_OP_WR_SLOT       4'hc
`define DPC_OP_SLOT_TO_WIPER 4'hd
`define DPC_OP_WIPER_TO_SLOT 4'he
`define DPC_OP_GLB_TO_WIPER  4'h1
`define DPC_OP_GLB_TO_SLOT   4'h8
`define DPC_OP_INCDEC        4'h2

// instruction byte field positions
`define DPC_OP_HI            7
`define DPC_OP_LO            4
`define DPC_SEL_HI_POS       3
`define DPC_SEL_LO_POS       2
`define DPC_ZERO_POS         1
`define DPC_POT_POS          0

// bit counter marks inside one byte frame
`define DPC_LAST_DATA_BIT    4'h7
`define DPC_ACK_BIT          4'h8
`define DPC_AFTER_ACK        4'h9

// reset values
`define DPC_WIPER_RST        8'h00
`define DPC_SLOT_RST         8'h80

`endif

/* include/dpc_pkg.sv */
// types shared by the dual pot serial command slave
`default_nettype none
package dpc_pkg;
    typedef logic [7:0] dpc_byte_t;
    typedef enum logic [2:0] {
        st_idle,
        st_id,
        st_instr,
        st_data,
        st_tx,
        st_incdec,
        st_wait
    } dpc_state_t;
endpackage : dpc_pkg
`default_nettype wire

/* sim/dpc_master.sv */
// two-wire bus master model
`default_nettype none
module dpc_master (
    // link
    output var logic scl,
    output var logic sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: clock high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit: data moves mid-low, read back while clock high
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #20 sda_low = !b;
        #20 scl = 1'b1;
        #20 r = sda;
        #20;
    endtask : bit_io
    // start: data falls while clock high
    task automatic start();
        scl = 1'b0;
        #20 sda_low = 1'b0;
        #20 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20;
    endtask : start
    // stop: data rises while clock high
    task automatic stop();
        scl = 1'b0;
        #20 sda_low = 1'b1;
        #20 scl = 1'b1;
        #20 sda_low = 1'b0;
        #20;
    endtask : stop
    // eight bits out, then read the acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte
    // eight bits in, then no acknowledge
    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask : rbyte
endmodule : dpc_master
`default_nettype wire

/* sim/dpc_slave_bench.sv */
// self-checking bench of the pot command slave
`default_nettype none
`include "dpc_cfg.svh"
module dpc_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned NV    = 600;
    localparam logic [3:0]  DTYPE = 4'h6;  // arbitrary value
    logic         clk, rst, scl, sda, sda_low, sda_o, sda_oe, write_protect_n, nv_busy;
    logic [3:0]   address_strap_inputs;
    logic [7:0]   wiper0, wiper1, v, r, idb;
    logic [255:0] tap_sel0, tap_sel1;
    logic [7:0]   wexp [2];
    logic [7:0]   sexp [2][4];
    logic [31:0]  rng;
    logic         ok, a, p;
    int           err_count, checks, cyc;

    // open-drain wire with pull-up
    assign sda = !(sda_oe || sda_low);
    assign idb = {DTYPE, address_strap_inputs};
    dpc_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
    dpc_slave #(.NV_WRITE_CYCLES(NV), .DEVICE_TYPE(DTYPE)) uut (
        .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_strap_inputs(address_strap_inputs), .write_protect_n(write_protect_n),
        .wiper0(wiper0), .wiper1(wiper1), .tap_sel0(tap_sel0), .tap_sel1(tap_sel1),
        .nv_busy(nv_busy));

    // system clock and hang limit
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            end_of_test();
        end
    end

    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction : rnd
    // expected wiper after one step
    function automatic logic [7:0] stepped(input logic [7:0] w, input logic up);
        if (up) return (w == 8'hff) ? w : w + 8'h01;
        return (w == 8'h00) ? w : w - 8'h01;
    endfunction : stepped

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // command: n=0 bare, 1 with data, 2 with read
    task automatic cmd(input logic [3:0] op, input logic [1:0] s, input logic pt,
                       input int n, input logic [7:0] d, output logic [7:0] rd,
                       output logic k);
        logic a0, a1, a2;
        m.start();
        m.wbyte(idb, a0);
        m.wbyte({op, s, 1'b0, pt}, a1);
        a2 = 1'b1;
        rd = 8'h00;
        if (n == 1) m.wbyte(d, a2);
        if (n == 2) m.rbyte(rd);
        m.stop();
        k = a0 && a1 && a2;
    endtask : cmd
    // poll until acknowledged; the first try is refused
    task automatic poll();
        logic ak, first;
        for (int k = 0; k < 20; k++) begin
            m.start();
            m.wbyte(idb, ak);
            m.stop();
            if (k == 0) first = ak;
            if (ak) break;
        end
        chk({6'h0, first, ak}, 8'h01);
    endtask : poll
    task automatic end_of_test();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        rng = 32'd7550;
        rst = 1'b1;
        write_protect_n = 1'b1;
        address_strap_inputs = 4'h0;
        repeat (8) @(posedge clk);
        v = rnd();
        rst <= 1'b0;
        address_strap_inputs <= v[3:0];
        repeat (8) @(posedge clk);
        chk(wiper0, `DPC_SLOT_RST);
        chk(wiper1, `DPC_SLOT_RST);
        foreach (sexp[i, j]) sexp[i][j] = `DPC_SLOT_RST;
        // wiper write and read back, range ends first
        for (int i = 0; i < 6; i++) begin
            v = (i < 2) ? {8{i[0]}} : rnd();
            p = i[0];
            cmd(`DPC_OP_WR_WIPER, 2'b00, p, 1, v, r, ok);
            chk({7'h0, ok}, 8'h01);
            wexp[p] = v;
            chk(p ? wiper1 : wiper0, v);
            cmd(`DPC_OP_RD_WIPER, 2'b00, p, 2, 8'h00, r, ok);
            chk(r, v);
        end
        $display("wiper test done");
        // every slot written, polled, read back
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            cmd(`DPC_OP_WR_SLOT, i[1:0], i[2], 1, v, r, ok);
            chk({7'h0, ok}, 8'h01);
            poll();
            sexp[i[2]][i[1:0]] = v;
        end
        for (int i = 0; i < 8; i++) begin
            cmd(`DPC_OP_RD_SLOT, i[1:0], i[2], 2, 8'h00, r, ok);
            chk(r, sexp[i[2]][i[1:0]]);
        end
        $display("slot test done");
        // moves between wipers and slots
        cmd(`DPC_OP_SLOT_TO_WIPER, 2'b10, 1'b0, 0, 8'h00, r, ok);
        chk(wiper0, sexp[0][2]);
        cmd(`DPC_OP_WIPER_TO_SLOT, 2'b11, 1'b1, 0, 8'h00, r, ok);
        poll();
        cmd(`DPC_OP_RD_SLOT, 2'b11, 1'b1, 2, 8'h00, r, ok);
        chk(r, wexp[1]);
        cmd(`DPC_OP_GLB_TO_WIPER, 2'b01, 1'b0, 0, 8'h00, r, ok);
        chk(wiper0, sexp[0][1]);
        chk(wiper1, sexp[1][1]);
        cmd(`DPC_OP_GLB_TO_SLOT, 2'b00, 1'b0, 0, 8'h00, r, ok);
        poll();
        for (int i = 0; i < 2; i++) begin
            cmd(`DPC_OP_RD_SLOT, 2'b00, i[0], 2, 8'h00, r, ok);
            chk(r, sexp[i][1]);
            sexp[i][0] = sexp[i][1];
        end
        $display("test moves done");
        // protected slot write changes nothing
        @(posedge clk);
        write_protect_n <= 1'b0;
        cmd(`DPC_OP_WR_SLOT, 2'b00, 1'b0, 1, ~sexp[0][0], r, ok);
        repeat (20) @(posedge clk);
        chk({7'h0, nv_busy}, 8'h00);
        write_protect_n <= 1'b1;
        cmd(`DPC_OP_RD_SLOT, 2'b00, 1'b0, 2, 8'h00, r, ok);
        chk(r, sexp[0][0]);
        $display("protect test done");
        // wrong type nibble, then wrong strap nibble
        for (int i = 0; i < 2; i++) begin
            m.start();
            m.wbyte(idb ^ (i ? 8'h0f : 8'hf0), a);
            m.stop();
            chk({7'h0, a}, 8'h00);
        end
        // undefined opcodes refused
        for (int i = 0; i < 16; i++) begin
            if (!(i[3:0] inside {4'h1, 4'h2, [4'h8:4'he]})) begin
                cmd(i[3:0], 2'b00, 1'b0, 1, rnd(), r, ok);
                chk({7'h0, ok}, 8'h00);
                chk(wiper0, sexp[0][1]);
            end
        end
        $display("test refusals done");
        // stepping pot 1: saturate at the top, then random
        wexp[1] = 8'hfe;
        cmd(`DPC_OP_WR_WIPER, 2'b00, 1'b1, 1, wexp[1], r, ok);
        m.start();
        m.wbyte(idb, a);
        m.wbyte({`DPC_OP_INCDEC, 2'b00, 1'b0, 1'b1}, ok);
        chk({6'h0, a, ok}, 8'h03);
        for (int i = 0; i < 14; i++) begin
            v = rnd();
            p = (i < 3) ? 1'b1 : v[0];
            m.bit_io(p, a);
            wexp[1] = stepped(wexp[1], p);
            chk(wiper1, wexp[1]);
        end
        m.stop();
        chk(wiper0, sexp[0][1]);
        $display("test stepping done");
        end_of_test();
    end
endmodule : dpc_slave_bench
`default_nettype wire

/* sim/dpc_slave_checker.sv */
// assertion checker on the slave's ports
`default_nettype none
module dpc_slave_checker #(
    parameter int unsigned NV_WRITE_CYCLES = 50
) (
    // system
    input wire logic         clk,
    input wire logic         rst,
    // two-wire link
    input wire logic         scl,
    input wire logic         sda_i,
    input wire logic         sda_o,
    input wire logic         sda_oe,
    // straps and protection
    input wire logic [3:0]   address_strap_inputs,
    input wire logic         write_protect_n,
    // pot state
    input wire logic [7:0]   wiper0,
    input wire logic [7:0]   wiper1,
    input wire logic [255:0] tap_sel0,
    input wire logic [255:0] tap_sel1,
    input wire logic         nv_busy
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] busy_cnt_ff;
    // cycles of the running write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt_ff <= 32'h0;
        end else if (nv_busy) begin
            busy_cnt_ff <= busy_cnt_ff + 32'h1;
        end else begin
            busy_cnt_ff <= 32'h0;
        end
    end
    // protect pin low past the synchroniser
    sequence s_wp_held;
        (!write_protect_n)[*4];
    endsequence
    // two busy cycles
    sequence s_busy_run;
        nv_busy ##1 nv_busy;
    endsequence
    property p_onehot0;
        $stable(wiper0) |-> tap_sel0 == (256'h1 << wiper0);
    endproperty
    property p_onehot1;
        $stable(wiper1) |-> tap_sel1 == (256'h1 << wiper1);
    endproperty
    property p_oe_scl_low;
        $changed(sda_oe) |-> !scl;
    endproperty
    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    property p_busy_len;
        $fell(nv_busy) |-> busy_cnt_ff == NV_WRITE_CYCLES;
    endproperty
    property p_wp_block;
        s_wp_held |-> !$rose(nv_busy);
    endproperty
    property p_busy_quiet_oe;
        nv_busy |-> !sda_oe;
    endproperty
    property p_busy_quiet_wiper;
        s_busy_run |-> $stable(wiper0) && $stable(wiper1);
    endproperty
    property p_wiper_on_high;
        $changed({wiper1, wiper0}) |-> scl;
    endproperty
    a_onehot0: assert property (p_onehot0)
        else $error("tap select 0 not one-hot of wiper 0");
    a_onehot1: assert property (p_onehot1)
        else $error("tap select 1 not one-hot of wiper 1");
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data drive changed while serial clock high");
    a_open_drain: assert property (p_open_drain)
        else $error("data output not low");
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    a_wp_block: assert property (p_wp_block)
        else $error("write cycle started while protected");
    a_busy_quiet_oe: assert property (p_busy_quiet_oe)
        else $error("data line driven during write cycle");
    a_busy_quiet_wiper: assert property (p_busy_quiet_wiper)
        else $error("wiper moved during write cycle");
    a_wiper_on_high: assert property (p_wiper_on_high)
        else $error("wiper changed while serial clock low");
endmodule : dpc_slave_checker

bind dpc_slave dpc_slave_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_strap_inputs(address_strap_inputs), .write_protect_n(write_protect_n),
    .wiper0(wiper0), .wiper1(wiper1), .tap_sel0(tap_sel0), .tap_sel1(tap_sel1),
    .nv_busy(nv_busy)
);
`default_nettype wire

/* src/dpc_slave.sv */
// two-wire slave and command decoder of a dual digital potentiometer
//
// Function
// - write-protect low blocks every nonvolatile slot write.
// - each wiper register drives a one-hot select of 256 taps.
// - data line changes only while clock low; high-clock changes mean start/stop.
// - commands begin with start; all traffic ignored until a start.
// - transmitter releases data after eight bits; receiver pulls low on ninth clock.
// - acknowledge matching id byte, instruction byte and a following data byte.
// - stop after nonvolatile write starts internal write; inputs disabled until done.
// - while busy the id byte gets no acknowledge; afterwards it does.
// - upper id nibble must equal the fixed device-type code.
// - lower id nibble must equal the four address straps.
// - two select bits index one of four slots, high bit most significant.
// - opcode in upper nibble, bit one zero, bit zero picks the pot.
// - read wiper returns the addressed wiper register.
// - write wiper loads the data byte into the addressed wiper.
// - read slot returns the chosen slot of the addressed pot.
// - write slot stores the data byte into the chosen slot.
// - copy the chosen slot of the addressed pot into its wiper.
// - copy the addressed wiper into the chosen slot.
// - global copy of the chosen slot into every wiper at once.
// - global copy of every wiper into its chosen slot.
// - increment/decrement opcode enables stepping of the addressed wiper.
// - after that acknowledge, each clock pulse steps up on data high, down on low.
// - a slot change completes within at most 10ms.
// - after power-up each wiper is loaded from its slot zero.
// - sample data on rising clock, drive data after falling clock.
`default_nettype none
`include "dpc_cfg.svh"

module dpc_slave #(
    parameter int unsigned NV_WRITE_CYCLES = `DPC_NV_WRITE_TIME_US * `DPC_CLK_MHZ,
    parameter logic [3:0]  DEVICE_TYPE     = 4'ha  // arbitrary value
) (
    // system
    input  wire logic         clk,
    input  wire logic         rst,
    // two-wire link
    input  wire logic         scl,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe,
    // straps and protection
    input  wire logic [3:0]   address_strap_inputs,
    input  wire logic         write_protect_n,
    // pot state
    output logic [7:0]        wiper0,
    output logic [7:0]        wiper1,
    output logic [255:0]      tap_sel0,
    output logic [255:0]      tap_sel1,
    output logic              nv_busy
);

    // one-hot tap decode of a wiper position
    function automatic logic [255:0] onehot(input dpc_pkg::dpc_byte_t w);
        logic [255:0] r;
        r    = 256'h0;
        r[w] = 1'b1;
        return r;
    endfunction : onehot

    // one step up or down, held at the array ends
    function automatic dpc_pkg::dpc_byte_t step(input dpc_pkg::dpc_byte_t w, input logic up);
        dpc_pkg::dpc_byte_t r;
        r = w;
        if (up && (w != 8'hff)) begin
            r = w + 8'h01;
        end else if (!up && (w != 8'h00)) begin
            r = w - 8'h01;
        end
        return r;
    endfunction : step

    // legality of an instruction byte
    function automatic logic instr_valid(input dpc_pkg::dpc_byte_t b);
        logic sel_zero;
        logic ok;
        sel_zero = (b[`DPC_SEL_HI_POS] == 1'b0) && (b[`DPC_SEL_LO_POS] == 1'b0);
        ok       = 1'b0;
        case (b[`DPC_OP_HI:`DPC_OP_LO])
            `DPC_OP_RD_WIPER, `DPC_OP_WR_WIPER, `DPC_OP_INCDEC: ok = sel_zero;
            `DPC_OP_RD_SLOT, `DPC_OP_WR_SLOT: ok = 1'b1;
            `DPC_OP_SLOT_TO_WIPER, `DPC_OP_WIPER_TO_SLOT: ok = 1'b1;
            `DPC_OP_GLB_TO_WIPER, `DPC_OP_GLB_TO_SLOT: ok = (b[`DPC_POT_POS] == 1'b0);
            default: ok = 1'b0;
        endcase
        return ok && (b[`DPC_ZERO_POS] == 1'b0);
    endfunction : instr_valid

    // state after the acknowledge of a legal instruction
    function automatic dpc_pkg::dpc_state_t instr_next(input dpc_pkg::dpc_byte_t b);
        dpc_pkg::dpc_state_t s;
        case (b[`DPC_OP_HI:`DPC_OP_LO])
            `DPC_OP_RD_WIPER, `DPC_OP_RD_SLOT: s = dpc_pkg::st_tx;
            `DPC_OP_WR_WIPER, `DPC_OP_WR_SLOT: s = dpc_pkg::st_data;
            `DPC_OP_INCDEC: s = dpc_pkg::st_incdec;
            default: s = dpc_pkg::st_wait;
        endcase
        return s;
    endfunction : instr_next

    // link domain: data bit capture on rising serial clock
    logic link_bit_ff;
    logic link_tgl_ff;

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            link_bit_ff <= 1'b0;
            link_tgl_ff <= 1'b0;
        end else begin
            link_bit_ff <= sda_i;
            link_tgl_ff <= ~link_tgl_ff; // one toggle per captured bit
        end
    end

    // pin and capture toggle synchronisers
    logic       scl_m_ff, scl_s_ff, scl_d_ff;
    logic       sda_m_ff, sda_s_ff, sda_d_ff;
    logic       tgl_m_ff, tgl_s_ff, tgl_d_ff;
    logic       wp_m_ff, wp_s_ff;
    logic [3:0] strap_m_ff, strap_s_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_m_ff   <= 1'b1;
            scl_s_ff   <= 1'b1;
            scl_d_ff   <= 1'b1;
            sda_m_ff   <= 1'b1;
            sda_s_ff   <= 1'b1;
            sda_d_ff   <= 1'b1;
            tgl_m_ff   <= 1'b0;
            tgl_s_ff   <= 1'b0;
            tgl_d_ff   <= 1'b0;
            wp_m_ff    <= 1'b0;
            wp_s_ff    <= 1'b0;
            strap_m_ff <= 4'h0;
            strap_s_ff <= 4'h0;
        end else begin
            scl_m_ff   <= scl;
            scl_s_ff   <= scl_m_ff;
            scl_d_ff   <= scl_s_ff;
            sda_m_ff   <= sda_i;
            sda_s_ff   <= sda_m_ff;
            sda_d_ff   <= sda_s_ff;
            tgl_m_ff   <= link_tgl_ff;
            tgl_s_ff   <= tgl_m_ff;
            tgl_d_ff   <= tgl_s_ff;
            wp_m_ff    <= write_protect_n;
            wp_s_ff    <= wp_m_ff;
            strap_m_ff <= address_strap_inputs;
            strap_s_ff <= strap_m_ff;
        end
    end

    // line events seen in the system domain
    logic start_ev;
    logic stop_ev;
    logic fall_ev;
    logic bit_ev;

    assign start_ev = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
    assign stop_ev  = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
    assign fall_ev  = scl_d_ff && !scl_s_ff;
    assign bit_ev   = tgl_s_ff ^ tgl_d_ff; // bit is stable until the next rising edge

    // protocol state
    dpc_pkg::dpc_state_t state_ff;
    dpc_pkg::dpc_state_t after_ack_ff;
    logic [3:0]          cnt_ff;
    dpc_pkg::dpc_byte_t  sr_ff;
    dpc_pkg::dpc_byte_t  instr_ff;
    logic                ack_ff;
    logic                oe_ff;
    logic                busy_ff;
    logic                pend_ff;
    logic [23:0]         busy_cnt_ff;
    logic                recall_ff;
    dpc_pkg::dpc_byte_t  wiper_ff [2];
    dpc_pkg::dpc_byte_t  slot_ff [2][4];
    logic [255:0]        tap0_ff;
    logic [255:0]        tap1_ff;

    // received byte and decode fields
    dpc_pkg::dpc_byte_t rx_byte;
    logic               byte_done;
    logic               id_ok;
    logic               instr_ok;
    logic               pot;
    logic [1:0]         sel;
    logic [3:0]         op;
    logic [1:0]         rx_sel;
    logic               rx_pot;
    dpc_pkg::dpc_byte_t tx_byte;

    assign rx_byte   = {sr_ff[6:0], link_bit_ff};
    assign byte_done = bit_ev && (cnt_ff == `DPC_LAST_DATA_BIT);
    assign id_ok     = (rx_byte[7:4] == DEVICE_TYPE)
                    && (rx_byte[3:0] == strap_s_ff)
                    && !busy_ff;
    assign instr_ok  = instr_valid(rx_byte);
    assign op        = instr_ff[`DPC_OP_HI:`DPC_OP_LO];
    assign pot       = instr_ff[`DPC_POT_POS];
    assign sel       = {instr_ff[`DPC_SEL_HI_POS], instr_ff[`DPC_SEL_LO_POS]};
    assign rx_pot    = rx_byte[`DPC_POT_POS];
    assign rx_sel    = {rx_byte[`DPC_SEL_HI_POS], rx_byte[`DPC_SEL_LO_POS]};
    assign tx_byte   = (rx_byte[`DPC_OP_HI:`DPC_OP_LO] == `DPC_OP_RD_WIPER)
                     ? wiper_ff[rx_pot]
                     : slot_ff[rx_pot][rx_sel];

    // byte framing, acknowledge and read-out shifting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff     <= dpc_pkg::st_idle;
            after_ack_ff <= dpc_pkg::st_idle;
            cnt_ff       <= 4'h0;
            sr_ff        <= 8'h00;
            instr_ff     <= 8'h00;
            ack_ff       <= 1'b0;
            oe_ff        <= 1'b0;
        end else if (start_ev) begin
            state_ff <= dpc_pkg::st_id;
            cnt_ff   <= 4'h0;
            oe_ff    <= 1'b0;
        end else if (stop_ev) begin
            state_ff <= dpc_pkg::st_idle;
            cnt_ff   <= 4'h0;
            oe_ff    <= 1'b0;
        end else begin
            case (state_ff)
                dpc_pkg::st_id, dpc_pkg::st_instr, dpc_pkg::st_data: begin
                    if (bit_ev && (cnt_ff < `DPC_ACK_BIT)) begin
                        cnt_ff <= cnt_ff + 4'h1;
                        sr_ff  <= rx_byte;
                        if (cnt_ff == `DPC_LAST_DATA_BIT) begin
                            if (state_ff == dpc_pkg::st_id) begin
                                ack_ff       <= id_ok;
                                after_ack_ff <= id_ok ? dpc_pkg::st_instr : dpc_pkg::st_wait;
                            end else if (state_ff == dpc_pkg::st_instr) begin
                                instr_ff     <= rx_byte;
                                ack_ff       <= instr_ok;
                                after_ack_ff <= instr_ok ? instr_next(rx_byte)
                                                         : dpc_pkg::st_wait;
                                sr_ff        <= tx_byte;
                            end else begin
                                ack_ff       <= 1'b1;
                                after_ack_ff <= dpc_pkg::st_wait;
                            end
                        end
                    end else if (bit_ev) begin
                        cnt_ff <= `DPC_AFTER_ACK; // ninth clock of the frame
                    end else if (fall_ev && (cnt_ff == `DPC_ACK_BIT)) begin
                        oe_ff <= ack_ff;
                    end else if (fall_ev && (cnt_ff == `DPC_AFTER_ACK)) begin
                        oe_ff    <= (after_ack_ff == dpc_pkg::st_tx) && !sr_ff[7];
                        cnt_ff   <= 4'h0;
                        state_ff <= after_ack_ff;
                    end
                end
                dpc_pkg::st_tx: begin
                    if (bit_ev) begin
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == `DPC_ACK_BIT) begin
                            state_ff <= dpc_pkg::st_wait; // master ack sampled
                        end
                    end else if (fall_ev && (cnt_ff < `DPC_ACK_BIT)) begin
                        oe_ff <= !sr_ff[6];
                        sr_ff <= {sr_ff[6:0], 1'b0};
                    end else if (fall_ev) begin
                        oe_ff <= 1'b0;
                    end
                end
                default: begin
                    oe_ff <= 1'b0; // idle, stepping or waiting
                end
            endcase
        end
    end

    // wiper registers: recall, direct write, transfers and stepping
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wiper_ff[0] <= `DPC_WIPER_RST;
            wiper_ff[1] <= `DPC_WIPER_RST;
            recall_ff   <= 1'b1;
        end else begin
            recall_ff <= 1'b0;
            if (recall_ff) begin
                wiper_ff[0] <= slot_ff[0][0];
                wiper_ff[1] <= slot_ff[1][0];
            end else if ((state_ff == dpc_pkg::st_instr) && byte_done && instr_ok) begin
                if (rx_byte[`DPC_OP_HI:`DPC_OP_LO] == `DPC_OP_SLOT_TO_WIPER) begin
                    wiper_ff[rx_pot] <= slot_ff[rx_pot][rx_sel];
                end else if (rx_byte[`DPC_OP_HI:`DPC_OP_LO] == `DPC_OP_GLB_TO_WIPER) begin
                    wiper_ff[0] <= slot_ff[0][rx_sel];
                    wiper_ff[1] <= slot_ff[1][rx_sel];
                end
            end else if ((state_ff == dpc_pkg::st_data) && byte_done
                         && (op == `DPC_OP_WR_WIPER)) begin
                wiper_ff[pot] <= rx_byte;
            end else if ((state_ff == dpc_pkg::st_incdec) && bit_ev) begin
                wiper_ff[pot] <= step(wiper_ff[pot], link_bit_ff);
            end
        end
    end

    // pending nonvolatile write, run at the stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_ff <= 1'b0;
        end else if (start_ev || stop_ev) begin
            pend_ff <= 1'b0;
        end else if ((state_ff == dpc_pkg::st_instr) && byte_done && instr_ok) begin
            pend_ff <= (rx_byte[`DPC_OP_HI:`DPC_OP_LO] == `DPC_OP_WIPER_TO_SLOT)
                    || (rx_byte[`DPC_OP_HI:`DPC_OP_LO] == `DPC_OP_GLB_TO_SLOT);
        end else if ((state_ff == dpc_pkg::st_data) && byte_done) begin
            pend_ff <= (op == `DPC_OP_WR_SLOT);
        end
    end

    // stored-setting slots, written at an unprotected stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < 2; p++) begin
                for (int s = 0; s < 4; s++) begin
                    slot_ff[p][s] <= `DPC_SLOT_RST;
                end
            end
        end else if (stop_ev && pend_ff && wp_s_ff) begin
            case (op)
                `DPC_OP_WR_SLOT: slot_ff[pot][sel] <= sr_ff;
                `DPC_OP_WIPER_TO_SLOT: slot_ff[pot][sel] <= wiper_ff[pot];
                `DPC_OP_GLB_TO_SLOT: begin
                    slot_ff[0][sel] <= wiper_ff[0];
                    slot_ff[1][sel] <= wiper_ff[1];
                end
                default: begin
                end
            endcase
        end
    end

    // internal write cycle timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff     <= 1'b0;
            busy_cnt_ff <= 24'h000000;
        end else if (stop_ev && pend_ff && wp_s_ff) begin
            busy_ff     <= 1'b1;
            busy_cnt_ff <= 24'(NV_WRITE_CYCLES - 1);
        end else if (busy_ff) begin
            if (busy_cnt_ff == 24'h000000) begin
                busy_ff <= 1'b0;
            end else begin
                busy_cnt_ff <= busy_cnt_ff - 24'h000001;
            end
        end
    end

    // tap switch selects
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap0_ff <= 256'h1;
            tap1_ff <= 256'h1;
        end else begin
            tap0_ff <= onehot(wiper_ff[0]);
            tap1_ff <= onehot(wiper_ff[1]);
        end
    end

    // outputs; the data pin is open drain and only ever pulled low
    assign sda_o    = 1'b0;
    assign sda_oe   = oe_ff;
    assign wiper0   = wiper_ff[0];
    assign wiper1   = wiper_ff[1];
    assign tap_sel0 = tap0_ff;
    assign tap_sel1 = tap1_ff;
    assign nv_busy  = busy_ff;

endmodule : dpc_slave
`default_nettype wire
